// ---- hdl/pwm_capture_timer16.sv ----
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module pwm_capture_timer16
  import pwm_capture_timer16_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_in,
  output logic timer_out,
  output logic timer_out_n,
  output logic timer_out_n_oe,
  output logic timer_irq
);

  //==============================================================
  // Registers and state
  logic [15:0] count;
  logic [15:0] reload;
  logic [15:0] compare;
  logic [7:0] hold_low;
  logic [7:0] control_one;
  logic [1:0] irq_cfg;
  logic capture_event_flag;
  run_state_t run_state;
  logic [6:0] prescale_cnt;
  logic in_meta;
  logic in_sync;
  logic in_prev;

  logic enable;
  logic output_polarity_select;
  logic [1:0] mode;
  logic [2:0] prescale;
  assign enable = control_one[pos_enable];
  assign output_polarity_select = control_one[pos_polarity];
  assign mode = control_one[pos_mode +: 2];
  assign prescale = control_one[pos_prescale +: 3];

  function automatic logic is_pwm(input logic [1:0] m);
    is_pwm = (m == mode_pwm_single) || (m == mode_pwm_dual);
  endfunction

  //==============================================================
  // AXI4-Lite write channel
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic wr_go;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'h0) && (a <= off_control_one);
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !s_axi_bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= resp_okay;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(aw_addr) ? resp_okay : resp_slverr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Only byte lane 0 carries register data
  logic wr_en;
  assign wr_en = wr_go && w_strb[0];

  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] off);
    wr_hit = (a == off);
  endfunction

  //==============================================================
  // AXI4-Lite read channel
  logic rd_go;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= resp_okay;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? resp_okay : resp_slverr;
      // Reads only observe; no counter state changes here
      if (s_axi_araddr == off_count_high) begin
        s_axi_rdata <= {24'h000000, count[15:8]};
      end else if (s_axi_araddr == off_count_low) begin
        s_axi_rdata <= {24'h000000, enable ? hold_low : count[7:0]};
      end else if (s_axi_araddr == off_reload_high) begin
        s_axi_rdata <= {24'h000000, reload[15:8]};
      end else if (s_axi_araddr == off_reload_low) begin
        s_axi_rdata <= {24'h000000, reload[7:0]};
      end else if (s_axi_araddr == off_compare_high) begin
        s_axi_rdata <= {24'h000000, compare[15:8]};
      end else if (s_axi_araddr == off_compare_low) begin
        s_axi_rdata <= {24'h000000, compare[7:0]};
      end else if (s_axi_araddr == off_control_zero) begin
        s_axi_rdata <= {29'h00000000, irq_cfg, capture_event_flag};
      end else if (s_axi_araddr == off_control_one) begin
        s_axi_rdata <= {24'h000000, control_one};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Low byte snapshot taken on a high-byte read while enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_low <= 8'h00;
    end else if (rd_go && s_axi_araddr == off_count_high && enable) begin
      hold_low <= count[7:0];
    end
  end

  //==============================================================
  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_one <= rst_control_one;
    end else if (wr_en && wr_hit(aw_addr, off_control_one)) begin
      control_one <= w_data[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_cfg <= rst_irq_cfg;
    end else if (wr_en && wr_hit(aw_addr, off_control_zero)) begin
      irq_cfg <= w_data[pos_irq_cfg +: 2];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload <= rst_reload;
    end else if (wr_en && wr_hit(aw_addr, off_reload_high)) begin
      reload[15:8] <= w_data[7:0];
    end else if (wr_en && wr_hit(aw_addr, off_reload_low)) begin
      reload[7:0] <= w_data[7:0];
    end
  end

  //==============================================================
  // Timer input synchroniser and edge qualification
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_meta <= 1'b0;
      in_sync <= 1'b0;
      in_prev <= 1'b0;
    end else begin
      in_meta <= timer_in;
      in_sync <= in_meta;
      in_prev <= in_sync;
    end
  end

  // No input exists while the shared pin drives the complement
  logic in_edge;
  assign in_edge = (mode != mode_pwm_dual) &&
                   (output_polarity_select ? (in_prev && !in_sync)
                                           : (!in_prev && in_sync));

  //==============================================================
  // Prescaler: divide by 2**prescale
  logic tick;
  logic [6:0] prescale_mask;
  assign prescale_mask = 7'((8'h01 << prescale) - 8'h01);
  assign tick = (run_state == st_run) && ((prescale_cnt & prescale_mask) == prescale_mask);

  always_ff @(posedge aclk) begin
    if (!aresetn || run_state != st_run) begin
      prescale_cnt <= 7'h00;
    end else begin
      prescale_cnt <= prescale_cnt + 7'h01;
    end
  end

  //==============================================================
  // Run control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_state <= st_idle;
    end else begin
      case (run_state)
        st_idle: begin
          if (enable) begin
            run_state <= (mode == mode_capture) ? st_arm : st_run;
          end
        end
        st_arm: begin
          if (!enable) begin
            run_state <= st_idle;
          end else if (in_edge) begin
            run_state <= st_run;
          end
        end
        default: begin
          if (!enable) begin
            run_state <= st_idle;
          end
        end
      endcase
    end
  end

  //==============================================================
  // Counter, capture and events
  logic at_reload;
  logic do_capture;
  assign at_reload = tick && (count == reload);
  assign do_capture = (run_state == st_run) && (mode == mode_capture) && in_edge;

  // Value the counter takes at this edge; shared by counting and capture
  logic [15:0] next_count;
  always_comb begin
    if (at_reload) begin
      next_count = 16'h0001;
    end else if (tick) begin
      next_count = count + 16'h0001;
    end else begin
      next_count = count;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= rst_count;
    end else if (wr_en && wr_hit(aw_addr, off_count_high)) begin
      count[15:8] <= w_data[7:0];
    end else if (wr_en && wr_hit(aw_addr, off_count_low)) begin
      count[7:0] <= w_data[7:0];
    end else begin
      count <= next_count;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare <= rst_compare;
    end else if (do_capture) begin
      // Take the count as it stands after this edge, so start-to-capture span is exact
      compare <= next_count;
    end else if (wr_en && wr_hit(aw_addr, off_compare_high)) begin
      compare[15:8] <= w_data[7:0];
    end else if (wr_en && wr_hit(aw_addr, off_compare_low)) begin
      compare[7:0] <= w_data[7:0];
    end
  end

  // Capture sets the flag even if a reload lands in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_event_flag <= 1'b0;
    end else if (do_capture) begin
      capture_event_flag <= 1'b1;
    end else if (at_reload && mode == mode_capture) begin
      capture_event_flag <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= (do_capture && irq_cfg != irq_cfg_reload_only) ||
                   (at_reload && irq_cfg != irq_cfg_capture_only);
    end
  end

  //==============================================================
  // Outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_out <= 1'b0;
    end else if (is_pwm(mode)) begin
      if (run_state != st_run || at_reload) begin
        timer_out <= output_polarity_select;
      end else if (tick && count == compare) begin
        timer_out <= !output_polarity_select;
      end
    end else if (at_reload) begin
      timer_out <= !timer_out;
    end
  end

  // The complement follows timer_out one cycle later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_out_n <= 1'b1;
      timer_out_n_oe <= 1'b0;
    end else begin
      timer_out_n <= !timer_out;
      timer_out_n_oe <= (mode == mode_pwm_dual);
    end
  end

endmodule

// ---- include/pwm_capture_timer16_pkg.sv ----
//==============================================================
// Summary of operation
// - Dual mode turns shared pin into complement
// - PWM period equals reload times 2**prescale
// - Preloaded start counts once up to reload
// - Polarity clear: high after compare match
// - Polarity set: high until compare match
// - Capture copies count into compare bytes
// - Polarity picks capture edge rising or falling
// - Capture raises interrupt, sets flag, keeps counting
// - Capture reload: interrupt, clear flag, continue
// - Interrupt source: both, capture or reload
// - Capture start on first edge, no interrupt
// - Captured value minus start times 2**prescale
// - Capture counts prescaled system clock only
// - Count reads never disturb timer
// - Enabled high read latches low byte into hold
// - Disabled low read returns live low byte
// - Non-PWM output toggles at every reload
// - Shared pin is input except dual mode
// - Enable bit written last starts counting
package pwm_capture_timer16_pkg;

  // Register byte offsets
  localparam logic [7:0] off_count_high = 8'h00;
  localparam logic [7:0] off_count_low = 8'h04;
  localparam logic [7:0] off_reload_high = 8'h08;
  localparam logic [7:0] off_reload_low = 8'h0c;
  localparam logic [7:0] off_compare_high = 8'h10;
  localparam logic [7:0] off_compare_low = 8'h14;
  localparam logic [7:0] off_control_zero = 8'h18;
  localparam logic [7:0] off_control_one = 8'h1c;

  // timer_control_zero fields
  localparam int pos_capture_flag = 0;
  localparam int pos_irq_cfg = 1;

  // timer_control_one fields
  localparam int pos_mode = 0;
  localparam int pos_prescale = 2;
  localparam int pos_polarity = 5;
  localparam int pos_enable = 7;

  // Mode codes
  localparam logic [1:0] mode_continuous = 2'h0;
  localparam logic [1:0] mode_pwm_single = 2'h1;
  localparam logic [1:0] mode_pwm_dual = 2'h2;
  localparam logic [1:0] mode_capture = 2'h3;

  // Interrupt source selections
  localparam logic [1:0] irq_cfg_capture_only = 2'h2;
  localparam logic [1:0] irq_cfg_reload_only = 2'h3;

  // Reset values
  localparam logic [15:0] rst_count = 16'h0001;
  localparam logic [15:0] rst_reload = 16'hffff;
  localparam logic [15:0] rst_compare = 16'h0000;
  localparam logic [7:0] rst_control_one = 8'h00;
  localparam logic [1:0] rst_irq_cfg = 2'h0;

  // AXI responses
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  typedef enum logic [1:0] {st_idle, st_arm, st_run} run_state_t;

endpackage

// ---- sim/timer_props.sv ----
`timescale 1ns/1ps
module timer_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_out,
  input wire logic timer_out_n,
  input wire logic timer_out_n_oe,
  input wire logic timer_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========================================
  // Pins and bus
  reset_release_a: assert property ($rose(aresetn) |-> !timer_out && timer_out_n &&
    !timer_out_n_oe && !timer_irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not at rest after reset");
  comp_pin_a: assert property (timer_out_n_oe |-> timer_out_n == !$past(timer_out))
    else $error("complement pin does not follow output");
  write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write response missing");
  write_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
  read_resp_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data missing");
  read_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not released");
  rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  cover property (timer_irq);
  cover property (timer_out_n_oe && $rose(timer_out));
  cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind pwm_capture_timer16 timer_props u_props (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .timer_out(timer_out),
  .timer_out_n(timer_out_n),
  .timer_out_n_oe(timer_out_n_oe),
  .timer_irq(timer_irq)
);

// ---- sim/pin_partner.sv ----
`timescale 1ns/1ps
module pin_partner (
  input wire logic aclk,
  input wire logic timer_out,
  input wire logic timer_out_n,
  input wire logic timer_out_n_oe,
  output logic timer_in
);
  logic src = 1'b0;
  logic prev = 1'b0;
  logic [15:0] since = 16'h0000;
  logic [15:0] per = 16'h0000;
  logic [15:0] hi = 16'h0000;
  // In dual mode the block owns the shared pin, so the input sees its complement
  assign timer_in = timer_out_n_oe ? timer_out_n : src;
  task automatic drive(input logic v);
    src <= v;
  endtask
  // Period is rise to rise, high time rise to fall, in clocks
  always @(posedge aclk) begin
    prev <= timer_out;
    since <= (timer_out && !prev) ? 16'h0001 : since + 16'h0001;
    if (timer_out && !prev) per <= since;
    if (!timer_out && prev) hi <= since;
  end
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import pwm_capture_timer16_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd;
  logic timer_in, timer_out, timer_out_n, timer_out_n_oe, timer_irq;
  logic [15:0] v0, v1;
  int miscompares = 0, n_checks = 0, irqs = 0, n0 = 0;
  always #25 aclk = ~aclk;
  always @(posedge aclk) if (timer_irq === 1'b1) irqs++;
  pwm_capture_timer16 uut (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .timer_in(timer_in),
    .timer_out(timer_out),
    .timer_out_n(timer_out_n),
    .timer_out_n_oe(timer_out_n_oe),
    .timer_irq(timer_irq)
  );
  pin_partner pp (.aclk(aclk), .timer_out(timer_out), .timer_out_n(timer_out_n),
    .timer_out_n_oe(timer_out_n_oe), .timer_in(timer_in));
  // ==========================================
  // Bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rdr(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(a + 8'h04, v[7:0]);
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    tally_and_finish();
  end
  // ==========================================
  // Scenarios
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdr(off_count_low);
    check(rd, 32'h01, "count low at reset");
    rdr(off_reload_high);
    check(rd, 32'hff, "reload high at reset");
    rdr(off_control_one);
    check(rd, 32'h00, "control one at reset");
    rdr(8'h20);
    check({rd[29:0], resp}, {30'h0, resp_slverr}, "unmapped read");
    wr(8'h20, 8'h11);
    check(resp, resp_slverr, "unmapped write");
    // Output toggles at each reload of a 4-count cycle, enable written last
    wr16(off_reload_high, 16'h0004);
    wr(off_control_one, 8'h80);
    check(resp, resp_okay, "write response");
    ticks(40);
    check({pp.per, pp.hi}, {16'd8, 16'd4}, "toggle period");
    // Interrupt source selection: both, capture only, reload only
    wr16(off_reload_high, 16'h000a);
    for (int c = 0; c < 4; c++) begin
      wr(off_control_zero, 8'(c << 1));
      n0 = irqs;
      ticks(100);
      check(32'((c == 2) ? (irqs == n0) : (irqs - n0 inside {[9:11]})), 32'h1, "irqs");
    end
    // Coherent read while running; live low byte once stopped
    wr16(off_reload_high, 16'hffff);
    rdr(off_count_high);
    v0[15:8] = rd[7:0];
    ticks(1000);
    rdr(off_count_low);
    v0[7:0] = rd[7:0];
    wr(off_control_one, 8'h00);
    rdr(off_count_high);
    v1[15:8] = rd[7:0];
    rdr(off_count_low);
    v1[7:0] = rd[7:0];
    check(32'((v1 - v0) inside {[1000:1040]}), 32'h1, "held low byte");
    wr(off_count_low, 8'h5a);
    rdr(off_count_low);
    check(rd, 32'h5a, "live low byte");
    // Pulse width: period 8 counts at divide 2, compare 3, both polarities
    for (int p = 0; p < 2; p++) begin
      wr(off_control_one, 8'h00);
      wr16(off_reload_high, 16'h0008);
      wr16(off_compare_high, 16'h0003);
      wr16(off_count_high, 16'h0001);
      wr(off_control_one, p ? 8'ha5 : 8'h85);
      ticks(80);
      check(pp.per, 16'd16, "pwm period");
      check(pp.hi, p ? 16'd6 : 16'd10, "pwm high time");
    end
    wr(off_control_one, 8'h86);
    ticks(40);
    check(timer_out_n_oe, 1'b1, "dual pin drive");
    check(pp.per, 16'd16, "dual period");
    check(pp.hi, 16'd10, "dual high time");
    // Capture: rising then falling edge select, 50 and 40 clocks after start
    wr16(off_reload_high, 16'h0100);
    // Preloaded near reload: first timeout long before a full count
    wr(off_control_one, 8'h00);
    wr16(off_count_high, 16'h00f0);
    n0 = irqs;
    wr(off_control_one, 8'h80);
    ticks(30);
    check(irqs - n0, 1, "preload first timeout");
    wr(off_control_zero, 8'h00);
    for (int p = 0; p < 2; p++) begin
      wr(off_control_one, 8'h00);
      check(timer_out_n_oe, 1'b0, "pin is input");
      wr16(off_count_high, 16'h0001);
      wr(off_control_one, p ? 8'ha3 : 8'h83);
      ticks(10);
      n0 = irqs;
      pp.drive(!p);
      ticks(20);
      check(irqs - n0, 0, "no irq on start edge");
      pp.drive(p);
      ticks(p ? 20 : 30);
      pp.drive(!p);
      ticks(10);
      check(irqs - n0, 1, "capture irq");
      wr(off_control_zero, 8'h00);
      rdr(off_control_zero);
      check(rd[0], 1'b1, "capture flag");
      rdr(off_compare_low);
      check(rd, p ? 32'h29 : 32'h33, "captured count");
      if (p == 0) begin
        ticks(250);
        rdr(off_control_zero);
        check(rd[0], 1'b0, "flag cleared at reload");
        check(irqs - n0, 2, "reload irq");
      end
    end
    tally_and_finish();
  end
endmodule
